// ==== core/fpec_ctrl.sv ====
`timescale 1ns/100ps
`include "fpec_consts.svh"
module fpec_ctrl (
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  input wire fpec_pkg::fpec_req_s REQ_IN,
  input wire logic START_IN,
  input wire logic VPP_OK_IN,
  input wire logic OTP_PROT_IN,
  input wire logic FETCH_EXT_IN,
  input wire logic [15:0] KEY_IN,
  input wire logic KEY_VLD_IN,
  output logic [15:0] RDATA_OUT,
  output logic TRAP_OUT,
  output logic FETCH_BLOCK_OUT,
  output logic PULSE_OUT,
  output fpec_pkg::fpec_cmd_s CMD_OUT
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  fpec_pkg::fpec_mode_e mode_q; // Operating mode
  logic wmode_q; // Write-mode flag
  logic [1:0] bank_q; // Bank erase select
  logic width_q; // Program width select
  logic [1:0] clk_sel_q; // Pulse clock select
  logic drop_q; // Supply drop seen
  logic prot_q; // Fetch protect enable
  logic erase_q; // Erase not program
  logic wen_q; // Write op enable
  logic [18:0] pulse_cnt_q; // Pulse timer
  logic [2:0] vpp_sync_q; // Supply level synchroniser
  logic vpp_ok_q; // Filtered supply level
  logic start_go; // Accepted start
  logic wr_ok; // Full word write allowed
  logic pulse_done; // Pulse timer expiry

  // Pulse length for a clock select code
  function automatic logic [18:0] pulse_len(input logic [1:0] sel);
    pulse_len = 19'(`FPEC_PULSE_CYC) << sel;
  endfunction : pulse_len

  // ----------------------------------------
  // Supply pin synchroniser
  // ----------------------------------------
  // Third stage agreement filters the pin
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      vpp_sync_q <= 3'h0;
      vpp_ok_q <= 1'h0;
    end else begin
      vpp_sync_q <= {vpp_sync_q[1:0], VPP_OK_IN};
      if (vpp_sync_q[1] == vpp_sync_q[2]) begin
        vpp_ok_q <= vpp_sync_q[2];
      end
    end
  end

  // Writes to the full word only in write mode
  assign wr_ok = REQ_IN.wr && !REQ_IN.odd &&
                 (mode_q == fpec_pkg::FPEC_WMODE);
  // Start only with write enable set, idle, and no word write racing it
  assign start_go = START_IN && wen_q && !REQ_IN.wr &&
                    (mode_q == fpec_pkg::FPEC_WMODE);
  assign pulse_done = (pulse_cnt_q == 19'h1);

  // ----------------------------------------
  // Mode machine
  // ----------------------------------------
  // Key entry, write mode, busy and exit
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      mode_q <= fpec_pkg::FPEC_STD;
    end else begin
      case (mode_q)
        fpec_pkg::FPEC_STD: begin
          if (KEY_VLD_IN && KEY_IN == `FPEC_KEY1) begin
            mode_q <= fpec_pkg::FPEC_KEYED;
          end
        end
        fpec_pkg::FPEC_KEYED: begin
          // Wrong second key rejects entry
          if (KEY_VLD_IN && KEY_IN == `FPEC_KEY2) begin
            mode_q <= fpec_pkg::FPEC_WMODE;
          end else if (KEY_VLD_IN || REQ_IN.wr) begin
            mode_q <= fpec_pkg::FPEC_STD;
          end
        end
        fpec_pkg::FPEC_WMODE: begin
          if (wr_ok && !REQ_IN.wdata[`FPEC_B_WMODE]) begin
            mode_q <= fpec_pkg::FPEC_STD;
          end else if (start_go) begin
            mode_q <= fpec_pkg::FPEC_BUSY;
          end
        end
        fpec_pkg::FPEC_BUSY: begin
          if (pulse_done) begin
            mode_q <= fpec_pkg::FPEC_WMODE;
          end
        end
        default: mode_q <= fpec_pkg::FPEC_STD;
      endcase
    end
  end

  // ----------------------------------------
  // Write-mode flag
  // ----------------------------------------
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      wmode_q <= 1'h0;
    end else if (mode_q == fpec_pkg::FPEC_KEYED && KEY_VLD_IN &&
                 KEY_IN == `FPEC_KEY2) begin
      wmode_q <= 1'h1;
    end else if (wr_ok && !REQ_IN.wdata[`FPEC_B_WMODE]) begin
      wmode_q <= 1'h0;
    end
  end

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  // Fields load only on whole-word writes in write mode
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      bank_q <= `FPEC_RST_BANK;
      width_q <= 1'h0;
      clk_sel_q <= `FPEC_RST_CLK;
      erase_q <= 1'h0;
      wen_q <= 1'h0;
    end else if (wr_ok && REQ_IN.wdata[`FPEC_B_WMODE]) begin
      bank_q <= REQ_IN.wdata[`FPEC_B_BANK_HI:`FPEC_B_BANK_LO];
      width_q <= REQ_IN.wdata[`FPEC_B_WIDTH];
      clk_sel_q <= REQ_IN.wdata[`FPEC_B_CLK_HI:`FPEC_B_CLK_LO];
      erase_q <= REQ_IN.wdata[`FPEC_B_ERASE];
      wen_q <= REQ_IN.wdata[`FPEC_B_WEN];
    end else if (wr_ok) begin
      // Leaving write mode drops the enable
      wen_q <= 1'h0;
      erase_q <= 1'h0;
    end
  end

  // ----------------------------------------
  // Protection enable
  // ----------------------------------------
  // Writable in any mode but busy; outside write mode only from flash
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      prot_q <= `FPEC_RST_PROT;
    end else if (REQ_IN.wr && !REQ_IN.odd && (wr_ok ||
                 (REQ_IN.from_flash && mode_q != fpec_pkg::FPEC_BUSY))) begin
      prot_q <= REQ_IN.wdata[`FPEC_B_BUSY];
    end
  end

  // ----------------------------------------
  // Pulse timer
  // ----------------------------------------
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      pulse_cnt_q <= 19'h0;
    end else if (start_go && mode_q == fpec_pkg::FPEC_WMODE) begin
      pulse_cnt_q <= pulse_len(clk_sel_q);
    end else if (pulse_cnt_q != 19'h0) begin
      pulse_cnt_q <= pulse_cnt_q - 19'h1;
    end
  end

  // ----------------------------------------
  // Supply drop flag
  // ----------------------------------------
  // Sticky over an operation, cleared at next start
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      drop_q <= 1'h0;
    end else if (mode_q == fpec_pkg::FPEC_BUSY && !vpp_ok_q) begin
      drop_q <= 1'h1;
    end else if (start_go) begin
      drop_q <= 1'h0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      RDATA_OUT <= 16'h0000;
      TRAP_OUT <= 1'h0;
      FETCH_BLOCK_OUT <= 1'h0;
      PULSE_OUT <= 1'h0;
      CMD_OUT <= '0;
    end else begin
      // Read image; bit 2 shows busy, not protection
      RDATA_OUT <= {wmode_q, 5'h00, bank_q, width_q, clk_sel_q, vpp_ok_q,
                    drop_q, mode_q == fpec_pkg::FPEC_BUSY, erase_q,
                    wen_q};
      TRAP_OUT <= (REQ_IN.wr || REQ_IN.rd) && REQ_IN.odd;
      FETCH_BLOCK_OUT <= prot_q && OTP_PROT_IN && FETCH_EXT_IN;
      PULSE_OUT <= (mode_q == fpec_pkg::FPEC_BUSY) && !pulse_done;
      // Mode decoded from enable, erase select and flag
      CMD_OUT.erase <= wen_q && wmode_q && erase_q;
      CMD_OUT.wide <= wen_q && wmode_q && !erase_q && width_q;
      CMD_OUT.bank <= (wen_q && wmode_q && erase_q) ? bank_q
                      : 2'h0;
      CMD_OUT.verify <= wen_q && wmode_q;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Accepted launch of a timed operation
  sequence s_start;
    start_go;
  endsequence
  // First key word taken in standard mode
  sequence s_key_first;
    mode_q == fpec_pkg::FPEC_STD && KEY_VLD_IN && KEY_IN == `FPEC_KEY1;
  endsequence
  // Second key word on the very next cycle
  sequence s_key_second;
    KEY_VLD_IN && KEY_IN == `FPEC_KEY2;
  endsequence
  // Whole-word write that leaves write mode
  sequence s_exit_write;
    wr_ok && !REQ_IN.wdata[`FPEC_B_WMODE];
  endsequence

  // Launch moves the machine into busy
  a_busy_on_start: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    s_start |=> mode_q == fpec_pkg::FPEC_BUSY)
    else $error("busy not set on start");
  // Busy shows on the read image one cycle later
  a_busy_read: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    s_start |=> ##1 RDATA_OUT[`FPEC_B_BUSY])
    else $error("busy not shown on read");
  // Timer expiry returns to idle write mode
  a_busy_ends: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    mode_q == fpec_pkg::FPEC_BUSY && pulse_done
    |=> mode_q == fpec_pkg::FPEC_WMODE)
    else $error("busy not cleared");
  // No busy without the write enable
  a_no_start_std: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    !wen_q |=> mode_q != fpec_pkg::FPEC_BUSY ||
    $past(mode_q) == fpec_pkg::FPEC_BUSY)
    else $error("start without enable");
  // Enable cannot change in standard mode
  a_lock_std: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    mode_q == fpec_pkg::FPEC_STD |=> $stable(wen_q))
    else $error("write in standard mode");
  // Odd access of either kind traps
  a_odd_trap: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    (REQ_IN.wr || REQ_IN.rd) && REQ_IN.odd |=> TRAP_OUT)
    else $error("odd access no trap");
  // Even or idle bus never traps
  a_trap_even: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    !REQ_IN.odd |=> !TRAP_OUT)
    else $error("trap without odd access");
  // Protection and option together block outside fetches
  a_fetch_block: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    prot_q && OTP_PROT_IN && FETCH_EXT_IN
    |=> FETCH_BLOCK_OUT)
    else $error("fetch not blocked");
  // Drop flag holds until the next launch
  a_drop_sticky: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    drop_q && !start_go |=> drop_q)
    else $error("drop flag lost");
  // Low supply while busy sets the drop flag
  a_drop_set: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    mode_q == fpec_pkg::FPEC_BUSY && !vpp_ok_q |=> drop_q)
    else $error("drop flag not set");
  // Enabled writes turn reads into verify reads
  a_verify_read: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    wen_q && wmode_q |=> CMD_OUT.verify)
    else $error("verify read missing");
  // Without the enable the array sees no command
  a_cmd_idle: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    !wen_q |=> !CMD_OUT.erase && !CMD_OUT.verify)
    else $error("command without enable");
  // Width select in programming mode gives double width
  a_wide_prog: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    wen_q && wmode_q && !erase_q && width_q |=> CMD_OUT.wide)
    else $error("wide program missing");
  // Standard mode never jumps straight to write mode
  a_key_entry: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    mode_q == fpec_pkg::FPEC_STD |=>
    mode_q != fpec_pkg::FPEC_WMODE)
    else $error("entry without key");
  // Both key words in a row enter write mode
  a_key_pair: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    s_key_first ##1 s_key_second
    |=> mode_q == fpec_pkg::FPEC_WMODE && wmode_q)
    else $error("key pair not accepted");
  // Clearing the flag leaves write mode
  a_exit_mode: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    s_exit_write |=> mode_q == fpec_pkg::FPEC_STD && !wmode_q && !wen_q)
    else $error("write mode not left");
  // Command word loads the bank field
  a_field_load: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    wr_ok && REQ_IN.wdata[`FPEC_B_WMODE] |=>
    bank_q == $past(REQ_IN.wdata[`FPEC_B_BANK_HI:`FPEC_B_BANK_LO]))
    else $error("bank field not loaded");
  // Outside code cannot touch protection in standard mode
  a_prot_ram: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    mode_q == fpec_pkg::FPEC_STD && REQ_IN.wr && !REQ_IN.from_flash
    |=> $stable(prot_q))
    else $error("protection changed from outside");
  // Launch loads the pulse length of the clock select
  a_pulse_load: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    s_start |=> pulse_cnt_q == pulse_len(clk_sel_q))
    else $error("pulse length wrong");

endmodule : fpec_ctrl

// ==== include/fpec_consts.svh ====
`ifndef FPEC_CONSTS_SVH
`define FPEC_CONSTS_SVH
// Control word field positions
`define FPEC_B_WMODE 15
`define FPEC_B_BANK_HI 9
`define FPEC_B_BANK_LO 8
`define FPEC_B_WIDTH 7
`define FPEC_B_CLK_HI 6
`define FPEC_B_CLK_LO 5
`define FPEC_B_SUPOK 4
`define FPEC_B_SUPDROP 3
`define FPEC_B_BUSY 2
`define FPEC_B_ERASE 1
`define FPEC_B_WEN 0
// Reset values
`define FPEC_RST_PROT 1'h1
`define FPEC_RST_BANK 2'h0
`define FPEC_RST_CLK 2'h0
// Key sequence words
`define FPEC_KEY1 16'hA5A5
`define FPEC_KEY2 16'h5A5A
// Pulse timing: base pulse in ns, cycles = ns / period
`define FPEC_PULSE_NS 12800
`define FPEC_CLK_PERIOD_NS 5
`define FPEC_PULSE_CYC (`FPEC_PULSE_NS / `FPEC_CLK_PERIOD_NS)
`endif

// ==== include/fpec_pkg.sv ====
package fpec_pkg;
  // Flash operating modes, gray along the usual path
  typedef enum logic [1:0] {
    FPEC_STD = 2'h0,
    FPEC_KEYED = 2'h1,
    FPEC_WMODE = 2'h3,
    FPEC_BUSY = 2'h2
  } fpec_mode_e;
  // Bus request to the control word
  typedef struct packed {
    logic wr;
    logic rd;
    logic odd;
    logic from_flash;
    logic [15:0] wdata;
  } fpec_req_s;
  // Array-side operation command
  typedef struct packed {
    logic erase;
    logic wide;
    logic [1:0] bank;
    logic verify;
  } fpec_cmd_s;
endpackage : fpec_pkg

// ==== dv/fpec_ctrl_bench.sv ====
`timescale 1ns/100ps
module fpec_ctrl_bench;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic mclk = 1'b0; // System clock
  logic rst = 1'b1; // Async reset
  fpec_pkg::fpec_req_s req = '0; // Control word request
  logic start = 1'b0; // Operation launch
  logic vpp = 1'b1; // Supply level
  logic otp = 1'b1; // One-time protection option
  logic fext = 1'b1; // Fetch from outside flash
  logic [15:0] key = 16'h0000; // Key word
  logic key_vld = 1'b0; // Key strobe
  logic [15:0] rdata; // Control word image
  logic trap; // Odd access trap
  logic fblk; // Fetch block
  logic pulse; // Pulse active
  fpec_pkg::fpec_cmd_s cmd; // Array command
  int bad_count = 0; // Mismatches
  int n_checks = 0; // Comparisons
  int cyc = 0; // Watchdog count
  int n; // Scratch count
  always #2.5 mclk = ~mclk;
  fpec_ctrl u_dut (.MCLK_IN(mclk), .SYS_RST_IN(rst), .REQ_IN(req),
    .START_IN(start), .VPP_OK_IN(vpp), .OTP_PROT_IN(otp),
    .FETCH_EXT_IN(fext), .KEY_IN(key), .KEY_VLD_IN(key_vld),
    .RDATA_OUT(rdata), .TRAP_OUT(trap), .FETCH_BLOCK_OUT(fblk),
    .PULSE_OUT(pulse), .CMD_OUT(cmd));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask : tick
  task automatic chk16(input string what, input logic [15:0] e,
                       input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk16
  task automatic chk1(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask : chk1
  task automatic wr_word(input logic [15:0] d, input logic ff);
    req = '{wr:1'b1, rd:1'b0, odd:1'b0, from_flash:ff, wdata:d};
    tick(1);
    req = '0;
    tick(3);
  endtask : wr_word
  task automatic send_key(input logic [15:0] k);
    key = k;
    key_vld = 1'b1;
    tick(1);
    key_vld = 1'b0;
    tick(1);
  endtask : send_key
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_locked;
    chk16("reset word", 16'h0010, rdata);
    chk1("reset block", 1'b1, fblk);
    wr_word(16'h8387, 1'b0);
    chk16("locked word", 16'h0010, rdata);
    send_key(16'hA5A5);
    send_key(16'h1234);
    wr_word(16'h8001, 1'b0);
    chk16("bad key", 16'h0010, rdata);
    send_key(16'hA5A5);
    wr_word(16'h8001, 1'b0);
    send_key(16'h5A5A);
    chk16("split key", 16'h0010, rdata);
    $display("locked test done");
  endtask : t_locked
  task automatic t_protect;
    wr_word(16'h0000, 1'b0);
    chk1("ram write prot", 1'b1, fblk);
    wr_word(16'h0000, 1'b1);
    chk1("flash clr prot", 1'b0, fblk);
    wr_word(16'h0004, 1'b1);
    chk1("flash set prot", 1'b1, fblk);
    otp = 1'b0;
    tick(3);
    chk1("no otp", 1'b0, fblk);
    otp = 1'b1;
    fext = 1'b0;
    tick(3);
    chk1("flash fetch", 1'b0, fblk);
    fext = 1'b1;
    req = '{wr:1'b0, rd:1'b1, odd:1'b1, from_flash:1'b1, wdata:16'h0000};
    n = 0;
    repeat (3) begin
      tick(1);
      req = '0;
      n += int'(trap === 1'b1);
    end
    chk1("trap once", 1'b1, n == 1);
    tick(1);
    $display("protect test done");
  endtask : t_protect
  task automatic t_config;
    send_key(16'hA5A5);
    send_key(16'h5A5A);
    tick(2);
    chk16("entered", 16'h8010, rdata);
    wr_word(16'h8323, 1'b1);
    chk16("erase word", 16'h8333, rdata);
    chk1("cmd erase", 1'b1, cmd.erase);
    chk16("cmd bank", 16'h0003, 16'(cmd.bank));
    chk1("verify", 1'b1, cmd.verify);
    chk1("no pulse", 1'b0, pulse);
    wr_word(16'h8081, 1'b1);
    chk16("prog word", 16'h8091, rdata);
    chk1("cmd wide", 1'b1, cmd.wide);
    chk1("cmd program", 1'b0, cmd.erase);
    $display("config test done");
  endtask : t_config
  task automatic t_run;
    wr_word(16'h8001, 1'b1);
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(3);
    chk1("busy", 1'b1, rdata[2]);
    chk1("pulse", 1'b1, pulse);
    vpp = 1'b0;
    tick(8);
    chk1("supply low", 1'b0, rdata[4]);
    vpp = 1'b1;
    n = 12;
    while (rdata[2] !== 1'b0 && n < 6000) begin
      tick(1);
      n++;
    end
    chk1("pulse length", 1'b1, n >= 2560 && n <= 2568);
    chk1("drop seen", 1'b1, rdata[3]);
    wr_word(16'h0000, 1'b1);
    chk16("exited", 16'h0000, rdata & 16'h8003);
    chk1("verify off", 1'b0, cmd.verify);
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(3);
    chk1("start refused", 1'b0, rdata[2] | pulse);
    $display("run test done");
  endtask : t_run
  // ----------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    tick(12);
    rst = 1'b0;
    tick(8);
    t_locked();
    t_protect();
    t_config();
    t_run();
    give_verdict();
  end
endmodule : fpec_ctrl_bench
